// ===== pkg/rps_pkg.sv
// Package for the rectifier power sequencer: register map, fields, timing.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
package rps_pkg;
	// Clock rate and timing
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned BYPASS_TO_EN_MS = 50;
	localparam int unsigned EN_TO_GOOD_MS = 50;
	// Register byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ = 4'h8;
	localparam logic [3:0] ADDR_MASK = 4'hc;
	// Control fields
	localparam int CTRL_RUN = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	// Event bits, shared by status and mask
	localparam int EV_BYPASS = 0;
	localparam int EV_ENABLE = 1;
	localparam int EV_GOOD = 2;
	localparam int EV_OVERV = 3;
	localparam int EV_UNDERV = 4;
	localparam int EV_DOWN = 5;
	localparam int EV_W = 6;
	localparam logic [EV_W-1:0] MASK_RST = 6'h00;
	// Sequencer states
	typedef enum logic [2:0] {
		RPS_IDLE, RPS_CHARGE, RPS_DOUBLED, RPS_BYPASS_WAIT, RPS_EN_WAIT, RPS_GOOD, RPS_FAULT
	} rps_state_e;
	// Synchronised comparator inputs
	typedef struct packed {
		logic slope_flat;
		logic above_180;
		logic above_200;
		logic above_205;
		logic above_235;
		logic above_400;
	} rps_cmp_s;
endpackage

// ===== pkg/rps_tmr_if.sv
// Interface between the sequencer and its millisecond timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rps_tmr_if;
	logic clear;
	logic [7:0] limit;
	logic done;
	modport seq (output clear, output limit, input done);
	modport tmr (input clear, input limit, output done);
endinterface

// ===== rtl/rps_timer.sv
// Prescaled millisecond timer for the power sequencer.
// Assumes clear is a synchronous request from the same clock domain.
`timescale 1ns/1ps
module rps_timer #(
	parameter int unsigned TICK = rps_pkg::TICK_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	rps_tmr_if.tmr t
);
	import rps_pkg::*;
	logic [$clog2(TICK)-1:0] pre_r;
	logic [7:0] ms_r;
	logic tick;

	// Prescaler needs at least two cycles per tick
	if (TICK < 2) begin : g_tick_check
		$error("rps_timer: TICK too small");
	end

	assign tick = (pre_r == ($clog2(TICK))'(TICK - 1));

	// Prescaler makes a one-cycle tick per millisecond
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= '0;
		end else if (t.clear || tick) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// Millisecond count, saturates at the limit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ms_r <= 8'h00;
		end else if (t.clear) begin
			ms_r <= 8'h00;
		end else if (tick && ms_r != t.limit) begin
			ms_r <= ms_r + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t.done <= 1'b0;
		end else begin
			t.done <= !t.clear && (ms_r == t.limit);
		end
	end
endmodule

// ===== rtl/rps_top.sv
// Rectifier power sequencer: strap, bypass, converter enable and bus-good.
// Assumes comparator levels arrive asynchronously from analog sense logic.
`timescale 1ns/1ps
//
// Contract
// - Bypass and strap open at power-up
// - Enable off, bus-good high until enabling
// - Flat slope below 200 V engages doubler
// - Flat slope above 235 V closes bypass
// - Enable converters 50 ms after bypass
// - Assert bus-good 50 ms after enable
// - Drop bus-good below 205 V
// - Disable converters below 200 V
// - Power back after disable restarts sequence
// - Brief dip above disable keeps state
// - Above 400 V disables converters
// - Overvoltage opens thermistor bypass
// - Below 180 V opens thermistor bypass
// - Bus-good low means bus normal
// - Enable low means converters disabled
module rps_top #(
	parameter int unsigned TICK = rps_pkg::TICK_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic slope_flat,
	input wire logic above_180,
	input wire logic above_200,
	input wire logic above_205,
	input wire logic above_235,
	input wire logic above_400,
	output logic bypass_close,
	output logic strap_close,
	output logic conv_en,
	output logic bus_good_n,
	output logic irq,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import rps_pkg::*;

	logic rst_s1_r, rst_n;
	rps_cmp_s cmp_s1_r, cmp_r;
	rps_state_e state_r, state_nxt;
	logic run_r;
	logic [EV_W-1:0] sts_r, mask_r, ev;
	logic bypass_nxt, strap_nxt, en_nxt, good_n_nxt;
	logic acc_done_r;
	logic wr_take;
	logic rd_take;
	rps_tmr_if tif ();

	// Prescaler needs at least two cycles per millisecond tick
	if (TICK < 2) begin : g_tick_check
		$error("rps_top: TICK too small");
	end

	// Both waits must fit the eight-bit millisecond limit of the timer
	if (BYPASS_TO_EN_MS > 255) begin : g_bypass_ms_check
		$error("rps_top: bypass wait out of range");
	end

	if (EN_TO_GOOD_MS > 255) begin : g_good_ms_check
		$error("rps_top: settle wait out of range");
	end

	// State groups decoded in several places
	function automatic logic st_powered(input rps_state_e s);
		return (s == RPS_EN_WAIT) || (s == RPS_GOOD);
	endfunction

	function automatic logic st_bypassed(input rps_state_e s);
		return (s == RPS_BYPASS_WAIT) || st_powered(s);
	endfunction

	// Strap carried on only while a doubled bus is in use; a fault drops it
	function automatic logic st_strap_keep(input rps_state_e s);
		return (s != RPS_IDLE) && (s != RPS_CHARGE) && (s != RPS_FAULT);
	endfunction

	// Status word: comparators, a spare zero, state and the four outputs
	function automatic logic [31:0] stat_word(input rps_cmp_s c, input rps_state_e s,
		input logic [3:0] o);
		return {18'h0, c, 1'b0, s, o};
	endfunction

	// Reset release through two flops, assert stays asynchronous
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// First synchroniser stage; nothing but the second stage reads it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_s1_r <= '0;
		end else begin
			cmp_s1_r <= '{slope_flat, above_180, above_200, above_205, above_235, above_400};
		end
	end

	// Second stage; all sequencing logic reads only this settled copy
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_r <= '0;
		end else begin
			cmp_r <= cmp_s1_r;
		end
	end

	rps_timer #(.TICK(TICK)) u_tmr (
		.mclk(mclk),
		.rst_n(rst_n),
		.t(tif.tmr)
	);

	// Timer restarts on every state change
	assign tif.clear = (state_nxt != state_r);
	assign tif.limit = (state_r == RPS_BYPASS_WAIT) ? 8'(BYPASS_TO_EN_MS) : 8'(EN_TO_GOOD_MS);

	// Sequencer next state; protection checks take priority
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RPS_IDLE: begin
				if (run_r) begin
					state_nxt = RPS_CHARGE;
				end
			end
			RPS_CHARGE: begin
				if (cmp_r.above_400) begin
					state_nxt = RPS_FAULT;
				end else if (cmp_r.slope_flat && !cmp_r.above_200) begin
					state_nxt = RPS_DOUBLED;
				end else if (cmp_r.slope_flat && cmp_r.above_235) begin
					state_nxt = RPS_BYPASS_WAIT;
				end
			end
			RPS_DOUBLED: begin
				if (cmp_r.above_400) begin
					state_nxt = RPS_FAULT;
				end else if (cmp_r.slope_flat && cmp_r.above_235) begin
					state_nxt = RPS_BYPASS_WAIT;
				end
			end
			RPS_BYPASS_WAIT: begin
				if (cmp_r.above_400) begin
					state_nxt = RPS_FAULT;
				end else if (!cmp_r.above_180) begin
					state_nxt = RPS_IDLE;
				end else if (tif.done) begin
					state_nxt = RPS_EN_WAIT;
				end
			end
			RPS_EN_WAIT, RPS_GOOD: begin
				if (cmp_r.above_400) begin
					state_nxt = RPS_FAULT;
				end else if (!cmp_r.above_200) begin
					state_nxt = RPS_IDLE;
				end else if (state_r == RPS_EN_WAIT && tif.done) begin
					state_nxt = RPS_GOOD;
				end
			end
			RPS_FAULT: begin
				if (!cmp_r.above_400) begin
					state_nxt = RPS_IDLE;
				end
			end
			default: state_nxt = RPS_IDLE;
		endcase
		if (!run_r) begin
			state_nxt = RPS_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RPS_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs decoded from the next state so they come straight from flops
	always_comb begin
		strap_nxt = (state_nxt == RPS_DOUBLED) ||
			(st_strap_keep(state_nxt) && strap_close);
		bypass_nxt = st_bypassed(state_nxt);
		en_nxt = st_powered(state_nxt);
		// Dip above the disable level only drops bus-good, state is kept
		good_n_nxt = !((state_nxt == RPS_GOOD) && cmp_r.above_205);
	end

	// Doubler strap; reset leaves it open
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_close <= 1'b0;
		end else begin
			strap_close <= strap_nxt;
		end
	end

	// Thermistor bypass; reset leaves it open
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bypass_close <= 1'b0;
		end else begin
			bypass_close <= bypass_nxt;
		end
	end

	// Converter enable; off until the sequence reaches its enabling step
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_en <= 1'b0;
		end else begin
			conv_en <= en_nxt;
		end
	end

	// Bus-good, active low; released high from reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_good_n <= 1'b1;
		end else begin
			bus_good_n <= good_n_nxt;
		end
	end

	// Events: rising edges of bypass and enable, the falling edge of bus_good_n (strap has none) and protection trips
	always_comb begin
		ev = '0;
		ev[EV_BYPASS] = bypass_nxt && !bypass_close;
		ev[EV_ENABLE] = en_nxt && !conv_en;
		ev[EV_GOOD] = !good_n_nxt && bus_good_n;
		ev[EV_OVERV] = (state_nxt == RPS_FAULT) && (state_r != RPS_FAULT);
		ev[EV_UNDERV] = (state_r == RPS_BYPASS_WAIT) && (state_nxt == RPS_IDLE) && run_r;
		ev[EV_DOWN] = (state_r == RPS_EN_WAIT || state_r == RPS_GOOD) &&
			(state_nxt == RPS_IDLE) && run_r;
	end

	// A write lands in the answer cycle, while waitrequest stands low
	assign wr_take = avs_write && acc_done_r && avs_byteenable[0];
	// Read data latched a cycle early so they stand in the answer cycle
	assign rd_take = avs_read && !acc_done_r;

	// Sticky status; a new event wins over a same-cycle clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sts_r <= '0;
		end else begin
			if (wr_take && avs_address == ADDR_IRQ) begin
				sts_r <= (sts_r & ~avs_writedata[EV_W-1:0]) | ev;
			end else begin
				sts_r <= sts_r | ev;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(sts_r & mask_r);
		end
	end

	// One wait state per access; acc_done_r marks the answer cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_done_r <= 1'b0;
		end else begin
			acc_done_r <= (avs_read || avs_write) && !acc_done_r;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && !acc_done_r);
		end
	end

	// Run bit; clearing it parks the sequencer with every switch open
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= CTRL_RST[CTRL_RUN];
		end else if (wr_take && avs_address == ADDR_CTRL) begin
			run_r <= avs_writedata[CTRL_RUN];
		end
	end

	// Interrupt mask, same layout as the status register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= MASK_RST;
		end else if (wr_take && avs_address == ADDR_MASK) begin
			mask_r <= avs_writedata[EV_W-1:0];
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			case (avs_address)
				ADDR_CTRL: avs_readdata <= {31'h0, run_r};
				ADDR_STAT: avs_readdata <= stat_word(cmp_r, state_r,
					{strap_close, bypass_close, conv_en, bus_good_n});
				ADDR_IRQ: avs_readdata <= {26'h0, sts_r};
				ADDR_MASK: avs_readdata <= {26'h0, mask_r};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ===== tb/rps_bus_model.sv
// Far-side bus model: line peak voltage to bus comparator levels.
// Assumes the strap doubles the bus at once, with no charging curve.
`timescale 1ns/1ps
module rps_bus_model (
	input wire logic [15:0] line_v,
	input wire logic strap,
	output logic [4:0] above
);
	logic [16:0] bus_v;
	// Doubled bus while the strap is engaged
	assign bus_v = strap ? {line_v, 1'h0} : {1'h0, line_v};
	// Levels for 400, 235, 205, 200, 180 V; no hysteresis, so no chatter
	assign above = {bus_v > 17'h190, bus_v > 17'h0eb, bus_v > 17'h0cd, bus_v > 17'h0c8,
		bus_v > 17'h0b4};
endmodule

// ===== tb/rps_top_chk.sv
// Checker on the sequencer ports, bound into the top module.
// Assumes a pin change reaches the outputs three cycles later.
`timescale 1ns/1ps
module rps_top_chk #(
	parameter int unsigned TICK = 10
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic slope_flat,
	input wire logic above_180,
	input wire logic above_200,
	input wire logic above_205,
	input wire logic above_235,
	input wire logic above_400,
	input wire logic bypass_close,
	input wire logic strap_close,
	input wire logic conv_en,
	input wire logic bus_good_n
);
	localparam int unsigned DLY = 50 * TICK;
	logic [15:0] bcnt_r;
	logic [15:0] ecnt_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Cycles with bypass closed and with converters on
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bcnt_r <= 16'h0;
			ecnt_r <= 16'h0;
		end else begin
			bcnt_r <= bypass_close ? bcnt_r + 16'h1 : 16'h0;
			ecnt_r <= conv_en ? ecnt_r + 16'h1 : 16'h0;
		end
	end
	a_reset_safe: assert property ($rose(rstn) |-> !bypass_close && !strap_close
		&& !conv_en && bus_good_n) else $error("outputs unsafe after reset");
	a_off_not_good: assert property (!conv_en [*2] |-> bus_good_n)
		else $error("bus good while off");
	a_strap_cause: assert property ($rose(strap_close) |-> $past(slope_flat, 3)
		&& !$past(above_200, 3)) else $error("strap without cause");
	a_bypass_cause: assert property ($rose(bypass_close) |-> $past(slope_flat, 3)
		&& $past(above_235, 3)) else $error("bypass without cause");
	a_enable_delay: assert property ($rose(conv_en) |-> bcnt_r >= DLY - 3
		&& bcnt_r <= DLY + 4) else $error("enable delay wrong");
	a_good_delay: assert property ($fell(bus_good_n) |-> conv_en && ecnt_r >= DLY - 3)
		else $error("bus good too early");
	a_down_good: assert property (!above_205 [*5] |-> bus_good_n)
		else $error("bus good below 205 V");
	a_down_off: assert property (!above_200 [*5] |-> !conv_en)
		else $error("enabled below 200 V");
	a_over_off: assert property (above_400 [*5] |-> !conv_en && !bypass_close)
		else $error("not shut down above 400 V");
	a_low_open: assert property (!above_180 [*5] |-> !bypass_close)
		else $error("bypass closed below 180 V");
	c_strap: cover property ($rose(strap_close));
	c_good: cover property ($fell(bus_good_n));
	c_over: cover property (above_400 && !conv_en);
endmodule
bind rps_top rps_top_chk #(.TICK(TICK)) i_rps_top_chk (.mclk, .rstn, .slope_flat, .above_180,
	.above_200, .above_205, .above_235, .above_400, .bypass_close, .strap_close, .conv_en,
	.bus_good_n);

// ===== tb/rps_top_tb.sv
// Bench for the sequencer: bus model, register tasks, queued checks.
// Assumes TICK of 10 cycles, so each 50 ms wait is near 500 cycles.
`timescale 1ns/1ps
module rps_top_tb;
	import rps_pkg::*;
	localparam logic [31:0] Z = 32'h0;
	logic mclk = 1'h0;
	logic rstn = 1'h0;
	logic flat = 1'h0;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [3:0] ad = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [15:0] line_v = 16'h0;
	logic [4:0] prev;
	logic [31:0] rnd;
	logic [31:0] rdat;
	logic wreq;
	logic [3:0] be = 4'hf;
	wire [4:0] ab;
	wire [4:0] ov;
	logic [4:0] oq[$];
	logic [63:0] rq[$];
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	int seed = 83;
	rps_top #(.TICK(10)) i_rps_top (.mclk(mclk), .rstn(rstn), .slope_flat(flat),
		.above_180(ab[0]), .above_200(ab[1]), .above_205(ab[2]), .above_235(ab[3]),
		.above_400(ab[4]), .irq(ov[4]), .strap_close(ov[3]), .bypass_close(ov[2]),
		.conv_en(ov[1]), .bus_good_n(ov[0]), .avs_address(ad), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wreq));
	rps_bus_model i_rps_bus_model (.line_v(line_v), .strap(ov[3]), .above(ab));
	// Clock and hang guard
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic miss(input string m);
		fail_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic cmp_out(input logic [4:0] got, input logic [4:0] exp);
		check_count++;
		if (got !== exp)
			miss($sformatf("outputs %b, wanted %b", got, exp));
	endtask
	task automatic cmp_rd(input logic [31:0] got, input logic [63:0] n);
		check_count++;
		if ((got & n[31:0]) !== n[63:32])
			miss($sformatf("read %h, wanted %h", got, n[63:32]));
	endtask
	// Watcher: read data, then every change of the outputs
	always @(posedge mclk) begin
		if (rd && wreq === 1'h0)
			cmp_rd(rdat, rq.pop_front());
		if (rstn && ov !== prev && oq.size() == 0)
			miss("unexpected output change");
		else if (rstn && ov !== prev)
			cmp_out(ov, oq.pop_front());
		prev <= ov;
	end
	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		int i;
		i = 0;
		if (!w)
			rq.push_back({e, m});
		@(posedge mclk);
		ad <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk);
			i++;
		end while (wreq !== 1'h0 && i < 50);
		if (i == 50)
			miss("no bus answer");
		wr <= 1'h0;
		rd <= 1'h0;
	endtask
	// Wait for all noted output changes, bounded
	task automatic settle();
		int i;
		i = 0;
		while (oq.size() != 0 && i < 1500) begin
			@(posedge mclk);
			i++;
		end
		if (oq.size() != 0)
			miss("output change missing");
		oq.delete();
	endtask
	task automatic step(input logic [15:0] v, input logic [4:0] e);
		line_v <= v;
		oq.push_back(e);
		settle();
	endtask
	task automatic power_up();
		line_v <= 16'h78;
		flat <= 1'h0;
		rnd = $random(seed);
		repeat ({1'h0, rnd[3:0]} + 5'h8) @(posedge mclk);
		flat <= 1'h1;
		oq.push_back(5'h09);
		oq.push_back(5'h0d);
		oq.push_back(5'h0f);
		oq.push_back(5'h0e);
		settle();
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence: registers, power-up, dips, drop, restart, overvoltage
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'h1;
		repeat (6) @(posedge mclk);
		bus(1'h0, ADDR_STAT, Z, 32'h1, 32'hf);
		bus(1'h0, ADDR_CTRL, Z, CTRL_RST, 32'h1);
		bus(1'h0, 4'h2, Z, Z, 32'hffffffff);
		be <= 4'he;
		bus(1'h1, ADDR_CTRL, Z, Z, Z);
		be <= 4'hf;
		bus(1'h0, ADDR_CTRL, Z, CTRL_RST, 32'h1);
		bus(1'h1, ADDR_CTRL, Z, Z, Z);
		bus(1'h0, ADDR_STAT, Z, {25'h0, RPS_IDLE, 4'h1}, 32'h7f);
		bus(1'h1, ADDR_CTRL, 32'h1, Z, Z);
		bus(1'h0, ADDR_STAT, Z, {25'h0, RPS_CHARGE, 4'h1}, 32'h7f);
		rnd = $random(seed);
		bus(1'h1, ADDR_MASK, rnd, Z, Z);
		bus(1'h0, ADDR_MASK, Z, rnd & 32'h3f, 32'h3f);
		bus(1'h1, ADDR_MASK, Z, Z, Z);
		power_up();
		oq.push_back(5'h1e);
		bus(1'h1, ADDR_MASK, 32'h4, Z, Z);
		settle();
		oq.push_back(5'h0e);
		bus(1'h1, ADDR_IRQ, 32'h3f, Z, Z);
		settle();
		bus(1'h0, ADDR_IRQ, Z, Z, 32'h3f);
		bus(1'h1, ADDR_MASK, Z, Z, Z);
		step(16'h65, 5'h0f);
		step(16'h78, 5'h0e);
		step(16'h65, 5'h0f);
		flat <= 1'h0;
		step(16'h55, 5'h01);
		power_up();
		step(16'hd2, 5'h01);
		line_v <= 16'hf0;
		oq.push_back(5'h05);
		oq.push_back(5'h07);
		oq.push_back(5'h06);
		settle();
		step(16'h1a0, 5'h01);
		bus(1'h0, ADDR_STAT, Z, 32'h1, 32'hf);
		bus(1'h0, ADDR_IRQ, Z, 32'h2f, 32'h3f);
		end_of_test();
	end
endmodule
